// >>> design/sah_defines.vh
`ifndef SAH_DEFINES_VH
`define SAH_DEFINES_VH
// ==========================================================
// register byte offsets
`define SAH_OFS_CTRL 8'h6C
`define SAH_OFS_CLEAR 8'h54
`define SAH_OFS_HOLD 8'h7C
`define SAH_OFS_ABORT 8'h80
// ==========================================================
// control register fields
`define SAH_CTRL_ENABLE 0
`define SAH_CTRL_ABORT_REQ 1
`define SAH_CTRL_MASTER_EN 2
`define SAH_CTRL_RESTART 3
`define SAH_CTRL_TEN_BIT 4
`define SAH_CTRL_CMD_SEL 5
`define SAH_CTRL_GC_OR_SB 6
`define SAH_CTRL_RESET 7'h00
// ==========================================================
// hold register fields
`define SAH_TXH_LSB 0
`define SAH_TXH_MSB 15
`define SAH_RXH_LSB 16
`define SAH_RXH_MSB 23
`define SAH_HOLD_RESET 24'h000000
// ==========================================================
// abort reason fields
`define SAH_AB_7B_NACK 0
`define SAH_AB_DATA_NACK 3
`define SAH_AB_GCALL_NACK 4
`define SAH_AB_SBYTE_NORST 9
`define SAH_AB_10B_RD_NORST 10
`define SAH_AB_MASTER_DIS 11
`define SAH_AB_ARBITRATION_LOST_FLAG 12
`define SAH_AB_SLV_FLUSH 13
`define SAH_AB_SLV_ARB 14
`define SAH_AB_SLV_RD_CMD 15
`define SAH_AB_USER 16
`define SAH_AB_RESET 17'h00000
`define SAH_CNT_LSB 23
`define SAH_CNT_MSB 31
`define SAH_CNT_RESET 9'h000
// ==========================================================
// minimum transmit hold in clock cycles per role
`define SAH_MIN_HOLD_MASTER 16'h0001
`define SAH_MIN_HOLD_SLAVE 16'h0007
`endif

// >>> design/sah_delay.v
`timescale 1ns/1ns
// ==========================================================
// one-shot down counter: done pulses count cycles after start
module sah_delay #(
  parameter W = 16
) (
  input wire clk_sys,
  input wire rst,
  input wire start,
  input wire [W-1:0] count,
  output reg done
);
  reg [W-1:0] cnt;
  reg busy;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt <= {W{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        // a new edge restarts the wait; zero behaves as one cycle
        cnt <= count;
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt <= {{(W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // sah_delay

// >>> design/sah_top.v
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ns
`include "sah_defines.vh"
// Function
// - hold timing register writes take effect only while controller enable is zero
// - both hold delays count whole clock periods
// - transmit hold applies only above role minimum: 1 master, 7 slave
// - receiver holds SDA while SCL high for bits 23-16 periods
// - transmitter holds SDA after SCL falls for bits 15-0 periods
// - bits 31-23 count flushed commands; zero while controller disabled
// - bit 16 set when master sees the software abort request
// - bit 15 set when slave read answered with read command word
// - bit 14 set when slave transmitter loses bus, with bit 12
// - slave read with stale TX data raises abort interrupt, sets bit 13
// - bit 12 set on master arbitration loss
// - bit 11 set when master operation starts with master disabled
// - bit 10 set on 10-bit read with restart disallowed
// - bit 9 cleared with cause present drops one cycle then returns
// - data byte not acknowledged after acked address sets abort bit 3
// - 7-bit address not acknowledged sets abort bit 0
// - general call not acknowledged sets abort bit 4
module sah_top (
  input wire clk_sys,
  input wire rst,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // I2C pins
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // controller side, same clock
  input wire master_role,
  input wire tx_active,
  input wire rx_active,
  input wire tx_bit,
  input wire master_abort_seen,
  input wire slave_read_with_read_cmd,
  input wire slave_bus_lost,
  input wire slave_read_req,
  input wire txfifo_not_empty,
  input wire master_arbitration_lost_flag,
  input wire master_op_start,
  input wire ten_bit_read_cmd,
  input wire data_byte_not_acked,
  input wire seven_bit_address_not_acked,
  input wire general_call_not_acked,
  input wire command_flushed,
  output reg ctrl_enable,
  output reg abort_request,
  output reg master_enable,
  output reg restart_allow,
  output reg ten_bit_mode,
  output reg command_select_a,
  output reg general_call_or_start_byte,
  output reg transmit_abort_interrupt,
  output reg rx_bit,
  output reg rx_bit_valid
);
  // ==========================================================
  // bus slave
  reg dp_write;
  reg [7:0] dp_addr;
  reg [15:0] tx_hold;
  reg [7:0] rx_hold;
  reg [16:0] abort_bits;
  reg [8:0] flushed_command_count;
  wire addr_phase;
  wire wr_ctrl;
  wire wr_hold;
  wire wr_clear;
  reg [31:0] next_rdata;

  assign addr_phase = hsel && htrans[1] && hready;
  assign wr_ctrl = dp_write && (dp_addr == `SAH_OFS_CTRL);
  assign wr_hold = dp_write && (dp_addr == `SAH_OFS_HOLD);
  assign wr_clear = dp_write && (dp_addr == `SAH_OFS_CLEAR);

  always @* begin
    next_rdata = 32'h00000000;
    if (haddr[7:0] == `SAH_OFS_CTRL) begin
      next_rdata[6:0] = {general_call_or_start_byte, command_select_a, ten_bit_mode,
        restart_allow, master_enable, abort_request, ctrl_enable};
    end else if (haddr[7:0] == `SAH_OFS_HOLD) begin
      next_rdata[`SAH_RXH_MSB:`SAH_RXH_LSB] = rx_hold;
      next_rdata[`SAH_TXH_MSB:`SAH_TXH_LSB] = tx_hold;
    end else if (haddr[7:0] == `SAH_OFS_ABORT) begin
      next_rdata[`SAH_CNT_MSB:`SAH_CNT_LSB] = flushed_command_count;
      next_rdata[16:0] = abort_bits;
    end else begin
      // clear register and unmapped words read as zero
      next_rdata = 32'h00000000;
    end
  end

  // reads are sampled in the address phase so that the data phase has no wait
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dp_write <= addr_phase && hwrite && (haddr[31:8] == 24'h000000);
      if (addr_phase) begin
        dp_addr <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= (haddr[31:8] == 24'h000000) ? next_rdata : 32'h00000000;
        end
      end
    end
  end

  // ==========================================================
  // control bits
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {general_call_or_start_byte, command_select_a, ten_bit_mode, restart_allow,
        master_enable, abort_request, ctrl_enable} <= `SAH_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_enable <= hwdata[`SAH_CTRL_ENABLE];
        master_enable <= hwdata[`SAH_CTRL_MASTER_EN];
        restart_allow <= hwdata[`SAH_CTRL_RESTART];
        ten_bit_mode <= hwdata[`SAH_CTRL_TEN_BIT];
        command_select_a <= hwdata[`SAH_CTRL_CMD_SEL];
        general_call_or_start_byte <= hwdata[`SAH_CTRL_GC_OR_SB];
      end
      // the request stays up until the master reports it or a control write clears it; the report wins over a write
      if (master_abort_seen) begin
        abort_request <= 1'b0;
      end else if (wr_ctrl) begin
        abort_request <= hwdata[`SAH_CTRL_ABORT_REQ];
      end
    end
  end

  // ==========================================================
  // hold timing register
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {rx_hold, tx_hold} <= `SAH_HOLD_RESET;
    end else if (wr_hold && !ctrl_enable) begin
      tx_hold <= hwdata[`SAH_TXH_MSB:`SAH_TXH_LSB];
      rx_hold <= hwdata[`SAH_RXH_MSB:`SAH_RXH_LSB];
    end
  end

  // ==========================================================
  // abort reasons and flush count
  wire sbyte_cause;
  reg [16:0] set_bits;

  // cause is a level: start byte selected while restart is disallowed
  assign sbyte_cause = ctrl_enable && !restart_allow && command_select_a &&
    general_call_or_start_byte;

  always @* begin
    set_bits = 17'h00000;
    set_bits[`SAH_AB_USER] = master_abort_seen && abort_request;
    set_bits[`SAH_AB_SLV_RD_CMD] = slave_read_with_read_cmd;
    set_bits[`SAH_AB_SLV_ARB] = slave_bus_lost;
    set_bits[`SAH_AB_SLV_FLUSH] = slave_read_req && txfifo_not_empty;
    set_bits[`SAH_AB_ARBITRATION_LOST_FLAG] = master_arbitration_lost_flag || slave_bus_lost;
    set_bits[`SAH_AB_MASTER_DIS] = master_op_start && !master_enable;
    set_bits[`SAH_AB_10B_RD_NORST] = ten_bit_read_cmd && ten_bit_mode &&
      !restart_allow;
    set_bits[`SAH_AB_DATA_NACK] = data_byte_not_acked;
    set_bits[`SAH_AB_7B_NACK] = seven_bit_address_not_acked && !ten_bit_mode;
    set_bits[`SAH_AB_GCALL_NACK] = general_call_not_acked;
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      abort_bits <= `SAH_AB_RESET;
    end else begin
      // a set in the clear cycle wins, so no event is lost
      abort_bits <= (wr_clear ? 17'h00000 : abort_bits) | set_bits;
      // this bit alone lets the clear win for one cycle, then its cause sets it again
      if (wr_clear) begin
        abort_bits[`SAH_AB_SBYTE_NORST] <= 1'b0;
      end else if (sbyte_cause) begin
        abort_bits[`SAH_AB_SBYTE_NORST] <= 1'b1;
      end
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flushed_command_count <= `SAH_CNT_RESET;
    end else if (!ctrl_enable) begin
      flushed_command_count <= `SAH_CNT_RESET;
    end else if (command_flushed && (flushed_command_count != 9'h1FF)) begin
      // saturates rather than wrapping to a misleading small value
      flushed_command_count <= flushed_command_count + 9'h001;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      transmit_abort_interrupt <= 1'b0;
    end else begin
      transmit_abort_interrupt <= |abort_bits;
    end
  end

  // ==========================================================
  // pin synchronisers and SCL edges
  reg scl_s1;
  reg scl_s2;
  reg scl_d;
  reg sda_s1;
  reg sda_s2;
  wire scl_fall;
  wire scl_rise;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
    end
  end

  assign scl_fall = scl_d && !scl_s2;
  assign scl_rise = !scl_d && scl_s2;

  // ==========================================================
  // hold delays
  wire [15:0] min_hold;
  wire [15:0] tx_count;
  wire tx_done;
  wire rx_done;

  assign min_hold = master_role ? `SAH_MIN_HOLD_MASTER : `SAH_MIN_HOLD_SLAVE;
  assign tx_count = (tx_hold > min_hold) ? tx_hold : min_hold;

  sah_delay #(
    .W(16)
  ) u_tx_delay (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(scl_fall && tx_active),
    .count(tx_count),
    .done(tx_done)
  );

  sah_delay #(
    .W(8)
  ) u_rx_delay (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(scl_rise && rx_active),
    .count(rx_hold),
    .done(rx_done)
  );

  // open drain: only a zero is driven; the bit changes only after the hold
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      if (!tx_active) begin
        sda_oe <= 1'b0;
      end else if (tx_done) begin
        sda_oe <= !tx_bit;
      end
    end
  end

  // receiver samples SDA once the hold after SCL rise has passed
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_bit <= 1'b1;
      rx_bit_valid <= 1'b0;
    end else begin
      rx_bit_valid <= rx_done && rx_active;
      if (rx_done) begin
        rx_bit <= sda_s2;
      end
    end
  end
endmodule // sah_top

// >>> verification/sah_checker.sv
`timescale 1ns/1ns
// ==========================================================
// port assertions
module sah_checker (
  input wire clk_sys,
  input wire rst,
  input wire [1:0] htrans,
  input wire scl_in,
  input wire master_role,
  input wire tx_active,
  input wire master_abort_seen,
  input wire slave_bus_lost,
  input wire slave_read_req,
  input wire txfifo_not_empty,
  input wire master_arbitration_lost_flag,
  input wire master_op_start,
  input wire data_byte_not_acked,
  input wire general_call_not_acked,
  input wire sda_oe,
  input wire master_enable,
  input wire transmit_abort_interrupt,
  input wire rx_bit_valid
);
  logic sp;
  logic [3:0] fa;
  logic [3:0] ra;
  wire irq = transmit_abort_interrupt;
  // cycles since scl fell and rose, saturating so idle time never wraps
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sp <= 1'h1;
      fa <= 4'hF;
      ra <= 4'hF;
    end else begin
      sp <= scl_in;
      fa <= (sp && !scl_in) ? 4'h0 : fa + {3'h0, fa != 4'hF};
      ra <= (!sp && scl_in) ? 4'h0 : ra + {3'h0, ra != 4'hF};
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_ABORT_EVT: assert property (
    (master_abort_seen || data_byte_not_acked || general_call_not_acked) |-> ##[1:2] irq)
    else $error("abort event raised no interrupt");
  AST_ARBITRATION_LOST_FLAG: assert property (
    (slave_bus_lost || master_arbitration_lost_flag) |=> ##[0:1] irq) else $error("no arbitration abort");
  AST_STALE: assert property (
    slave_read_req && txfifo_not_empty |-> ##[1:2] irq) else $error("no stale flush abort");
  AST_MDIS: assert property (
    master_op_start && !master_enable |=> ##[0:1] irq) else $error("no master disabled abort");
  AST_STICKY: assert property (
    $fell(irq) |-> $past(htrans[1], 2) || $past(htrans[1], 3) || $past(htrans[1], 4))
    else $error("abort cleared without software");
  AST_TX_OFF: assert property (
    !tx_active |=> !sda_oe) else $error("sda driven while not transmitting");
  // three edges of sync and edge detect plus the master minimum of one
  AST_TX_HOLD: assert property (
    tx_active && master_role && $changed(sda_oe) |-> fa >= 4'h4)
    else $error("sda changed inside hold");
  AST_RX_HOLD: assert property (
    rx_bit_valid |-> ra >= 4'h4) else $error("sample taken inside hold");
endmodule // sah_checker

bind sah_top sah_checker u_chk (.clk_sys, .rst, .htrans, .scl_in, .master_role, .tx_active,
  .master_abort_seen, .slave_bus_lost, .slave_read_req, .txfifo_not_empty, .master_arbitration_lost_flag,
  .master_op_start, .data_byte_not_acked, .general_call_not_acked, .sda_oe, .master_enable,
  .transmit_abort_interrupt, .rx_bit_valid);

// >>> verification/sah_peer.sv
`timescale 1ns/1ns
// ==========================================================
// remote party: scl toggles only inside a frame, sda has a pull-up
module sah_peer (
  input wire run,
  input wire sda_oe,
  input wire peer_bit,
  output logic scl,
  output wire sda
);
  initial scl = 1'h1;
  always begin
    wait (run);
    #80 scl = 1'h0;
    #80 scl = 1'h1;
  end
  assign sda = !(sda_oe || !peer_bit);
endmodule // sah_peer

// >>> verification/test_i2c_sda_hold_and_abort_source.sv
`timescale 1ns/1ns
`define CK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
// ==========================================================
// bench
module test_i2c_sda_hold_and_abort_source;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [10:0] ev = 11'h0;
  logic hwrite = 1'h0, master_role = 1'h0, tx_active = 1'h0, rx_active = 1'h0, tx_bit = 1'h1;
  logic txfifo_not_empty = 1'h0, run = 1'h0, peer_bit = 1'h1;
  wire [31:0] hrdata;
  wire [6:0] ctl;
  wire hreadyout, hresp, scl_in, sda_in, sda_out, sda_oe, rx_bit, rx_bit_valid, irq;
  int fail_count = 0;
  int cmp_count = 0;
  logic [31:0] am [0:9] = '{32'h10000, 32'h8000, 32'h5000, 32'h2000, 32'h1000, 32'h800,
    32'h400, 32'h8, 32'h1, 32'h10};
  always #10 clk_sys = ~clk_sys;
  sah_top dut (.clk_sys, .rst, .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .scl_in, .sda_in, .sda_out, .sda_oe,
    .master_role, .tx_active, .rx_active, .tx_bit, .master_abort_seen(ev[0]),
    .slave_read_with_read_cmd(ev[1]), .slave_bus_lost(ev[2]), .slave_read_req(ev[3]),
    .txfifo_not_empty, .master_arbitration_lost_flag(ev[4]), .master_op_start(ev[5]),
    .ten_bit_read_cmd(ev[6]), .data_byte_not_acked(ev[7]),
    .seven_bit_address_not_acked(ev[8]), .general_call_not_acked(ev[9]),
    .command_flushed(ev[10]), .ctrl_enable(ctl[0]), .abort_request(ctl[1]),
    .master_enable(ctl[2]), .restart_allow(ctl[3]), .ten_bit_mode(ctl[4]),
    .command_select_a(ctl[5]), .general_call_or_start_byte(ctl[6]),
    .transmit_abort_interrupt(irq), .rx_bit, .rx_bit_valid);
  sah_peer u_peer (.run, .sda_oe, .peer_bit, .scl(scl_in), .sda(sda_in));
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // bounded wait on ready or on a received sample
  task waitfor(input logic rx);
    for (int k = 0; k <= 200; k++) begin
      @(posedge clk_sys);
      #1;
      if ((rx ? rx_bit_valid : hreadyout) === 1'h1)
        return;
    end
    fail_count++;
    tally_and_finish;
  endtask
  // single word transfer; on a read d is the expected value
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    waitfor(1'h0);
    htrans <= 2'h0;
    hwdata <= d;
    waitfor(1'h0);
    `CK(hresp, 1'h0)
    if (!w)
      `CK(hrdata, d)
  endtask
  task pulse(input int i);
    @(posedge clk_sys);
    ev <= 11'h1 << i;
    @(posedge clk_sys);
    ev <= 11'h0;
  endtask
  task t_regs;
    ahb(1'h0, 32'h80, 32'h0);
    ahb(1'h0, 32'h7C, 32'h0);
    ahb(1'h1, 32'h7C, 32'hFFFFFFFF);
    ahb(1'h0, 32'h7C, 32'h00FFFFFF);
    ahb(1'h1, 32'h6C, 32'h1);
    ahb(1'h1, 32'h7C, 32'h5);
    ahb(1'h0, 32'h7C, 32'h00FFFFFF);
    ahb(1'h0, 32'h90, 32'h0);
    $display("test regs done");
  endtask
  task t_abort;
    for (int i = 0; i < 10; i++) begin
      // the user abort bit is only taken while the abort request is up
      ahb(1'h1, 32'h6C, i == 0 ? 32'h3 : (i == 6 ? 32'h11 : 32'h1));
      txfifo_not_empty <= (i == 3);
      pulse(i);
      ahb(1'h0, 32'h80, am[i]);
      `CK(irq, 1'h1)
      ahb(1'h1, 32'h54, 32'h0);
      ahb(1'h0, 32'h80, 32'h0);
    end
    ahb(1'h1, 32'h6C, 32'h61);
    `CK(ctl, 7'h61)
    ahb(1'h0, 32'h80, 32'h200);
    ahb(1'h1, 32'h54, 32'h0);
    ahb(1'h0, 32'h80, 32'h200);
    ahb(1'h1, 32'h6C, 32'h69);
    ahb(1'h1, 32'h54, 32'h0);
    ahb(1'h0, 32'h80, 32'h0);
    $display("test abort done");
  endtask
  task t_flush;
    ahb(1'h1, 32'h6C, 32'h1);
    repeat (3) pulse(10);
    ahb(1'h0, 32'h80, 32'h01800000);
    ahb(1'h1, 32'h6C, 32'h0);
    ahb(1'h0, 32'h80, 32'h0);
    $display("test flush done");
  endtask
  // edges after the first one that sees scl low, until sda_oe follows a new tx_bit
  task t_hold(input logic role, input logic [4:0] exp);
    logic prev;
    logic want;
    int n;
    prev = 1'h0;
    // scl is looked at on the falling clock edge, clear of its own changes
    @(negedge clk_sys);
    for (n = 0; n < 20 && !(prev && !scl_in); n++) begin
      prev = scl_in;
      @(negedge clk_sys);
    end
    if (n == 20)
      fail_count++;
    @(posedge clk_sys);
    want = !sda_oe;
    master_role <= role;
    tx_bit <= sda_oe;
    for (n = 0; n < 20 && sda_oe !== want; n++) begin
      @(posedge clk_sys);
      #1;
    end
    `CK(5'(n), exp)
  endtask
  task t_link;
    ahb(1'h1, 32'h7C, 32'h00020002);
    master_role <= 1'h1;
    tx_bit <= 1'h0;
    tx_active <= 1'h1;
    run <= 1'h1;
    repeat (40) @(posedge clk_sys);
    #1;
    `CK(sda_in, 1'h0)
    `CK(sda_out, 1'h0)
    // sync and edge detect add three edges to the hold actually applied
    t_hold(1'h1, 5'h05);
    t_hold(1'h0, 5'h0A);
    tx_active <= 1'h0;
    repeat (2) @(posedge clk_sys);
    #1;
    `CK(sda_oe, 1'h0)
    rx_active <= 1'h1;
    for (int b = 0; b < 2; b++) begin
      peer_bit <= b[0];
      // the first sample may predate the new level
      waitfor(1'h1);
      waitfor(1'h1);
      `CK(rx_bit, b[0])
    end
    run <= 1'h0;
    $display("test link done");
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'h0;
    t_regs;
    t_abort;
    t_flush;
    t_link;
    tally_and_finish;
  end
endmodule // test_i2c_sda_hold_and_abort_source
